// [include/color_sensor_pkg.sv]
// Shared constants and types for the colour light sensor readout
package color_sensor_pkg;

    // ****************************************
    // Converter and timing constants
    // ****************************************
    localparam int CHANNELS = 4;
    localparam int RESULT_W = 16;
    localparam int STEP_IN_W = 11;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned STEP_TIME_NS = 2400000;
    localparam int unsigned STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam logic [8:0] MAX_STEPS = 9'h100;
    localparam logic [8:0] LAST_STEP = 9'h001;
    localparam logic [15:0] RESULT_MAX = 16'hffff;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [3:0] PERSIST_MAX = 4'hf;
    localparam logic [3:0] PERSIST_MIN = 4'h1;

    // ****************************************
    // Two-wire target constants
    // ****************************************
    localparam logic [6:0] TARGET_ADDR_MAIN = 7'h29;
    localparam logic [6:0] TARGET_ADDR_ALT = 7'h39;
    localparam logic [7:0] CLEAR_INT_CMD = 8'he6;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Four channel results, clear in the top word
    typedef struct packed {
        logic [15:0] clear;
        logic [15:0] red;
        logic [15:0] green;
        logic [15:0] blue;
    } color_set_type;

    // Counts per integration step from the analog front end
    typedef struct packed {
        logic [10:0] clear;
        logic [10:0] red;
        logic [10:0] green;
        logic [10:0] blue;
    } step_counts_type;

    // Interrupt window on the clear channel
    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } window_type;

    typedef enum logic [1:0] {
        SEQ_SLEEP,
        SEQ_IDLE,
        SEQ_WAIT,
        SEQ_CONV
    } seq_state_type;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ACK_A,
        BUS_WRITE,
        BUS_ACK_W,
        BUS_READ,
        BUS_ACK_R
    } bus_state_type;

endpackage

// [design/color_sensor_readout.sv]
// Colour light sensor digital core: sequencer, converters, interrupt, serial target

// Notes on behaviour
// - Four channels integrate together, 16-bit results
// - Results copied to buffer at conversion end
// - One state machine times wait and conversion
// - Programmable wait period between measurements
// - Gain and integration time host selectable
// - Interrupt asserted and held until cleared
// - Upper and lower thresholds form window
// - Consecutive out-of-window count; in-window restarts
// - Interrupt pin only pulled low or released
// - Two-wire target, clock is input only
// - Reset to sleep; start wakes, checks power
// - Wait then conversion repeats while enabled
// - Steps of 2.4 ms, 1 to 256
module color_sensor_readout
    import color_sensor_pkg::*;
#(
    parameter int unsigned STEP_CYCLES_P = STEP_CYCLES,
    parameter bit ADDR_ALT_P = 1'b0
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic int_in,
    output logic int_out,
    output logic int_oe_out,
    input wire logic power_on_bit_in,
    input wire logic color_conv_enable_in,
    input wire logic int_enable_in,
    input wire logic [7:0] integ_time_setting_in,
    input wire logic [7:0] wait_time_setting_in,
    input wire logic [1:0] analog_gain_setting_in,
    input wire logic [3:0] persist_in,
    input wire window_type window_in,
    input wire step_counts_type chan_step_in,
    output logic [1:0] analog_gain_out,
    output color_set_type results_out,
    output logic data_valid_out,
    output logic sleep_out
);

    // ****************************************
    // Functions
    // ****************************************
    // Saturating accumulate so bright light clips instead of wrapping
    function automatic logic [15:0] sat_add(input logic [15:0] a,
                                            input logic [10:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {6'h00, b};
        return s[16] ? RESULT_MAX : s[15:0];
    endfunction

    // Byte k: clear low, clear high, red, green, blue
    function automatic logic [7:0] pick_byte(input color_set_type c,
                                             input logic [2:0] k);
        logic [3:0][15:0] w;
        logic [15:0] word;
        w = c;
        word = w[2'h3 - k[2:1]];
        return k[0] ? word[15:8] : word[7:0];
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
    logic start_det, stop_det, scl_rise, scl_fall;

    // Bus clock is sampled only, never driven
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    assign start_det = scl_s_r & sda_d_r & ~sda_s_r;
    assign stop_det = scl_s_r & ~sda_d_r & sda_s_r;
    assign scl_rise = scl_s_r & ~scl_d_r;
    assign scl_fall = ~scl_s_r & scl_d_r;

    // ****************************************
    // Measurement sequencer
    // ****************************************
    seq_state_type seq_r, seq_nxt;
    logic [31:0] step_cnt_r, step_cnt_nxt;
    logic [8:0] steps_r, steps_nxt;
    logic [3:0][15:0] acc_r, acc_nxt;
    color_set_type res_r, res_nxt;
    logic valid_r, valid_nxt, pend_r, pend_nxt, clr_cmd_r, sleep_r, sleep_nxt;
    logic [1:0] gain_r, gain_nxt;
    logic [3:0] oow_r, oow_nxt, oow_inc, persist_req;
    logic step_tick, run_ok, conv_done, out_win, fire;
    logic [3:0][10:0] step_v;

    assign step_v = chan_step_in;
    assign run_ok = power_on_bit_in & color_conv_enable_in;
    assign step_tick = (step_cnt_r == STEP_CYCLES_P - 1);
    assign persist_req = (persist_in == 4'h0) ? PERSIST_MIN : persist_in;
    assign oow_inc = (oow_r == PERSIST_MAX) ? PERSIST_MAX : 4'(oow_r + 4'h1);
    assign out_win = (acc_nxt[3] < window_in.low) || (acc_nxt[3] > window_in.high);

    // Next state of sequencer, converters, buffer and interrupt
    always_comb begin
        seq_nxt = seq_r;
        step_cnt_nxt = step_cnt_r;
        steps_nxt = steps_r;
        acc_nxt = acc_r;
        res_nxt = res_r;
        valid_nxt = valid_r;
        gain_nxt = gain_r;
        oow_nxt = oow_r;
        pend_nxt = pend_r;
        conv_done = 1'b0;
        fire = 1'b0;
        // Step timer runs only while waiting or converting
        if (seq_r == SEQ_WAIT || seq_r == SEQ_CONV) begin
            step_cnt_nxt = step_tick ? 32'h0 : 32'(step_cnt_r + 32'h1);
        end
        case (seq_r)
            SEQ_SLEEP: begin
                if (start_det) begin
                    seq_nxt = SEQ_IDLE;
                end
            end
            SEQ_IDLE: begin
                if (!power_on_bit_in) begin
                    seq_nxt = SEQ_SLEEP;
                end else if (color_conv_enable_in) begin
                    seq_nxt = SEQ_WAIT;
                    steps_nxt = MAX_STEPS - {1'b0, wait_time_setting_in};
                    step_cnt_nxt = 32'h0;
                end
            end
            SEQ_WAIT: begin
                if (!run_ok) begin
                    seq_nxt = SEQ_IDLE;
                end else if (step_tick && steps_r == LAST_STEP) begin
                    seq_nxt = SEQ_CONV;
                    steps_nxt = MAX_STEPS - {1'b0, integ_time_setting_in};
                    acc_nxt = '0;
                    gain_nxt = analog_gain_setting_in;
                end else if (step_tick) begin
                    steps_nxt = 9'(steps_r - LAST_STEP);
                end
            end
            SEQ_CONV: begin
                if (!run_ok) begin
                    seq_nxt = SEQ_IDLE;
                end else if (step_tick) begin
                    for (int ch = 0; ch < CHANNELS; ch++) begin
                        acc_nxt[ch] = sat_add(acc_r[ch], step_v[ch]);
                    end
                    if (steps_r == LAST_STEP) begin
                        conv_done = 1'b1;
                        seq_nxt = SEQ_IDLE;
                    end else begin
                        steps_nxt = 9'(steps_r - LAST_STEP);
                    end
                end
            end
            default: seq_nxt = SEQ_SLEEP;
        endcase
        // All four words land together, never a mix
        if (conv_done) begin
            res_nxt = acc_nxt;
            valid_nxt = 1'b1;
            if (out_win) begin
                oow_nxt = oow_inc;
                fire = int_enable_in && (oow_inc >= persist_req);
            end else begin
                oow_nxt = 4'h0;
            end
        end
        // A new event in the clearing cycle still wins
        if (clr_cmd_r) begin
            pend_nxt = 1'b0;
        end
        if (fire) begin
            pend_nxt = 1'b1;
        end
        // Registered so the sleep output is glitch free
        sleep_nxt = (seq_nxt == SEQ_SLEEP);
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seq_r <= SEQ_SLEEP;
            step_cnt_r <= 32'h0;
            steps_r <= 9'h000;
            acc_r <= '0;
            res_r <= {CHANNELS{RESULT_RESET}};
            valid_r <= 1'b0;
            gain_r <= 2'h0;
            oow_r <= 4'h0;
            pend_r <= 1'b0;
            sleep_r <= 1'b1;
        end else begin
            seq_r <= seq_nxt;
            step_cnt_r <= step_cnt_nxt;
            steps_r <= steps_nxt;
            acc_r <= acc_nxt;
            res_r <= res_nxt;
            valid_r <= valid_nxt;
            gain_r <= gain_nxt;
            oow_r <= oow_nxt;
            pend_r <= pend_nxt;
            sleep_r <= sleep_nxt;
        end
    end

    // ****************************************
    // Two-wire target
    // ****************************************
    bus_state_type bus_r, bus_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt, next_byte;
    logic [2:0] ptr_r, ptr_nxt;
    color_set_type snap_r, snap_nxt;
    logic rw_r, rw_nxt, nack_r, nack_nxt, oe_r, oe_nxt, clr_nxt;
    logic [6:0] dev_addr;

    assign dev_addr = ADDR_ALT_P ? TARGET_ADDR_ALT : TARGET_ADDR_MAIN;
    assign next_byte = pick_byte(snap_r, ptr_r);

    // Drive changes on falling clock so data is stable while high
    always_comb begin
        bus_nxt = bus_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        tx_nxt = tx_r;
        ptr_nxt = ptr_r;
        snap_nxt = snap_r;
        rw_nxt = rw_r;
        nack_nxt = nack_r;
        oe_nxt = oe_r;
        clr_nxt = 1'b0;
        if (start_det) begin
            bus_nxt = BUS_ADDR;
            bit_cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (stop_det) begin
            bus_nxt = BUS_IDLE;
            oe_nxt = 1'b0;
        end else if (scl_rise) begin
            case (bus_r)
                BUS_ADDR, BUS_WRITE: begin
                    shift_nxt = {shift_r[6:0], sda_s_r};
                    bit_cnt_nxt = 4'(bit_cnt_r + 4'h1);
                end
                BUS_READ: bit_cnt_nxt = 4'(bit_cnt_r + 4'h1);
                BUS_ACK_R: nack_nxt = sda_s_r;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (bus_r)
                BUS_ADDR: begin
                    if (bit_cnt_r == BITS_PER_BYTE) begin
                        if (shift_r[7:1] == dev_addr) begin
                            bus_nxt = BUS_ACK_A;
                            oe_nxt = 1'b1;
                            rw_nxt = shift_r[0];
                        end else begin
                            bus_nxt = BUS_IDLE;
                        end
                    end
                end
                BUS_ACK_A: begin
                    bit_cnt_nxt = 4'h0;
                    if (rw_r) begin
                        // Snapshot keeps a multi-byte read coherent
                        snap_nxt = res_r;
                        tx_nxt = pick_byte(res_r, 3'h0);
                        ptr_nxt = 3'h1;
                        oe_nxt = ~tx_nxt[7];
                        bus_nxt = BUS_READ;
                    end else begin
                        oe_nxt = 1'b0;
                        bus_nxt = BUS_WRITE;
                    end
                end
                BUS_WRITE: begin
                    if (bit_cnt_r == BITS_PER_BYTE) begin
                        bus_nxt = BUS_ACK_W;
                        oe_nxt = 1'b1;
                        clr_nxt = (shift_r == CLEAR_INT_CMD);
                    end
                end
                BUS_ACK_W: begin
                    bus_nxt = BUS_WRITE;
                    bit_cnt_nxt = 4'h0;
                    oe_nxt = 1'b0;
                end
                BUS_READ: begin
                    if (bit_cnt_r == BITS_PER_BYTE) begin
                        bus_nxt = BUS_ACK_R;
                        oe_nxt = 1'b0;
                    end else begin
                        tx_nxt = {tx_r[6:0], 1'b0};
                        oe_nxt = ~tx_r[6];
                    end
                end
                BUS_ACK_R: begin
                    if (nack_r) begin
                        bus_nxt = BUS_IDLE;
                    end else begin
                        tx_nxt = next_byte;
                        ptr_nxt = 3'(ptr_r + 3'h1);
                        oe_nxt = ~next_byte[7];
                        bit_cnt_nxt = 4'h0;
                        bus_nxt = BUS_READ;
                    end
                end
                default: bus_nxt = BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_r <= BUS_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 3'h0;
            snap_r <= '0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            oe_r <= 1'b0;
            clr_cmd_r <= 1'b0;
        end else begin
            bus_r <= bus_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
            ptr_r <= ptr_nxt;
            snap_r <= snap_nxt;
            rw_r <= rw_nxt;
            nack_r <= nack_nxt;
            oe_r <= oe_nxt;
            clr_cmd_r <= clr_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic zero_r;

    // Constant low level for both open-drain pins
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            zero_r <= 1'b0;
        end else begin
            zero_r <= 1'b0;
        end
    end

    assign sda_out = zero_r;
    assign sda_oe_out = oe_r;
    assign int_out = zero_r;
    assign int_oe_out = pend_r;
    assign analog_gain_out = gain_r;
    assign results_out = res_r;
    assign data_valid_out = valid_r;
    assign sleep_out = sleep_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_conv_end;
        seq_r == SEQ_CONV && run_ok && step_tick && steps_r == LAST_STEP;
    endsequence

    sequence s_addr_miss;
        bus_r == BUS_ADDR && scl_fall && !start_det && !stop_det &&
            bit_cnt_r == BITS_PER_BYTE && shift_r[7:1] != dev_addr;
    endsequence

    a_int_held: assert property (pend_r && !clr_cmd_r |=> pend_r)
        else $error("interrupt dropped without clear");
    a_int_cause: assert property ($rose(pend_r) |->
        $past(conv_done) && $past(int_enable_in))
        else $error("interrupt raised without cause");
    a_buf_update: assert property (!$stable(res_r) |-> $past(conv_done))
        else $error("results changed outside conversion end");
    a_conv_end: assert property (s_conv_end |=> seq_r == SEQ_IDLE && valid_r)
        else $error("conversion end not taken");
    a_sleep_hold: assert property (seq_r == SEQ_SLEEP && !start_det |=> seq_r == SEQ_SLEEP)
        else $error("left sleep without start");
    a_idle_sleep: assert property (seq_r == SEQ_IDLE && !power_on_bit_in |=> seq_r == SEQ_SLEEP)
        else $error("idle did not return to sleep");
    a_conv_entry: assert property ($rose(seq_r == SEQ_CONV) |-> $past(seq_r) == SEQ_WAIT)
        else $error("conversion entered without wait");
    a_persist_clear: assert property (s_conv_end ##0 !out_win |=> oow_r == 4'h0)
        else $error("in-window result did not restart count");
    a_addr_ignore: assert property (s_addr_miss |=> bus_r == BUS_IDLE && !oe_r)
        else $error("foreign address answered");
    a_int_drive: assert property (int_out == 1'b0 && sda_out == 1'b0)
        else $error("open-drain pin driven high");

endmodule

// [verification/host_bus_model.sv]
// Host controller model: drives the two-wire bus toward the sensor
module host_bus_model
    import color_sensor_pkg::*;
#(
    parameter int HALF_P = 30
) (
    input wire logic clk_in,
    input wire logic dev_oe_in,
    output logic scl_out,
    output logic sda_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Line drive
    // ****************************************
    logic pull_r = 1'b0;
    // Pulled-up data line, low while either side pulls it
    assign sda_out = ~(pull_r | dev_oe_in);
    // Clock comes only from here, idle high between frames
    initial scl_out = 1'b1;

    // ****************************************
    // Bus conditions and bits
    // ****************************************
    // Half bit of 30 cycles keeps the bit rate near 312 kHz
    task automatic half();
        repeat (HALF_P) @(posedge clk_in);
        #2;
    endtask

    // Data moves only with the clock low, a few cycles after its fall
    task automatic put_bit(input logic b, output logic seen);
        repeat (4) @(posedge clk_in);
        #2;
        pull_r = ~b;
        half();
        scl_out = 1'b1;
        half();
        seen = sda_out;
        scl_out = 1'b0;
    endtask

    task automatic start_cond();
        pull_r = 1'b1;
        half();
        scl_out = 1'b0;
        half();
    endtask

    task automatic stop_cond();
        repeat (4) @(posedge clk_in);
        #2;
        pull_r = 1'b1;
        half();
        scl_out = 1'b1;
        half();
        pull_r = 1'b0;
        half();
    endtask

    // Clearing the flag is always an explicit write from here
    task automatic write_byte(input logic [7:0] d, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, s);
        acked = ~s;
    endtask

    task automatic read_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
        end
        put_bit(last, s);
    endtask
endmodule

// [verification/tb_color_sensor_readout.sv]
// Self-checking bench for the colour sensor readout
module tb_color_sensor_readout import color_sensor_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned STEP_P = 20;
    localparam int LIMIT = 60000;

    typedef struct packed {
        logic [7:0] integ;
        logic [1:0] gain;
        step_counts_type cnt;
    } row_type;

    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda, sda_oe, sda_o, int_o, int_oe, valid, asleep;
    logic power_on = 1'b0, conv_en = 1'b0, int_en = 1'b0;
    logic [7:0] integ = 8'hfe, wait_time_setting = 8'hfc;
    logic [1:0] gain = 2'h0, gain_o;
    logic [3:0] persist = 4'h1;
    window_type window = '0;
    step_counts_type steps = '{11'h001, 11'h002, 11'h003, 11'h004};
    color_set_type res;
    int n_fail = 0, checks_done = 0, cyc = 0, wake_cyc = 0, valid_cyc = 0, int_cyc = 0;
    logic asleep_q = 1'b1, valid_q = 1'b0, int_q = 1'b0;
    // Longest row is 256 steps, the saturating one 48
    row_type rows [4] = '{
        '{8'hff, 2'h0, '{11'h001, 11'h002, 11'h003, 11'h004}},
        '{8'hfe, 2'h1, '{11'h7ff, 11'h100, 11'h000, 11'h055}},
        '{8'h00, 2'h2, '{11'h001, 11'h003, 11'h000, 11'h002}},
        '{8'hd0, 2'h3, '{11'h7ff, 11'h400, 11'h7ff, 11'h001}}};

    initial begin
        forever #25 clk = ~clk;
    end

    color_sensor_readout #(.STEP_CYCLES_P(STEP_P), .ADDR_ALT_P(1'b0)) dut (
        .core_clk_in(clk), .rstn_in(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .int_in(~int_oe), .int_out(int_o),
        .int_oe_out(int_oe), .power_on_bit_in(power_on), .color_conv_enable_in(conv_en),
        .int_enable_in(int_en), .integ_time_setting_in(integ), .wait_time_setting_in(wait_time_setting),
        .analog_gain_setting_in(gain), .persist_in(persist), .window_in(window),
        .chan_step_in(steps), .analog_gain_out(gain_o), .results_out(res),
        .data_valid_out(valid), .sleep_out(asleep));

    host_bus_model #(.HALF_P(30)) host (
        .clk_in(clk), .dev_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("Error %0t ns: %s", $time, what);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #2;
    endtask

    // Saturating product of step count and counts per step
    function automatic logic [15:0] sat(input int n, input logic [10:0] v);
        int p;
        p = n * int'(v);
        return (p > 65535) ? 16'hffff : p[15:0];
    endfunction

    function automatic color_set_type expect_set(input logic [7:0] t, input step_counts_type c);
        int n;
        n = 256 - int'(t);
        return '{sat(n, c.clear), sat(n, c.red), sat(n, c.green), sat(n, c.blue)};
    endfunction

    task automatic send(input logic [6:0] a, input logic [7:0] d, output logic acked);
        logic da;
        host.start_cond();
        host.write_byte({a, 1'b0}, acked);
        if (acked === 1'b1) host.write_byte(d, da);
        host.stop_cond();
    endtask

    // Nine bytes, so the pointer wrap is seen too
    task automatic read_check(input color_set_type e);
        logic ok;
        logic [7:0] b;
        logic [7:0] eb [9];
        eb = '{e.clear[7:0], e.clear[15:8], e.red[7:0], e.red[15:8], e.green[7:0],
            e.green[15:8], e.blue[7:0], e.blue[15:8], e.clear[7:0]};
        host.start_cond();
        host.write_byte({TARGET_ADDR_MAIN, 1'b1}, ok);
        check(ok === 1'b1, "read address refused");
        for (int k = 0; k < 9; k++) begin
            host.read_byte(k == 8, b);
            check(b === eb[k], "read byte");
        end
        host.stop_cond();
    endtask

    // Event times, open-drain pin values and the hang limit
    always @(posedge clk) begin
        cyc++;
        if (asleep_q === 1'b1 && asleep === 1'b0) wake_cyc = cyc;
        if (valid_q === 1'b0 && valid === 1'b1) valid_cyc = cyc;
        if (int_q === 1'b0 && int_oe === 1'b1) int_cyc = cyc;
        asleep_q = asleep;
        valid_q = valid;
        int_q = int_oe;
        // Pins are unknown until the first reset edge has passed
        if (rst_n === 1'b1) check(sda_o === 1'b0 && int_o === 1'b0, "pin driven high");
        if (cyc == LIMIT) begin
            n_fail++;
            conclude();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic ok;
        int k0;
        color_set_type e;
        repeat (12) @(posedge clk);
        #2;
        rst_n = 1'b1;
        check(asleep === 1'b1 && valid === 1'b0 && res === '0, "reset state");
        check(int_oe === 1'b0 && sda_oe === 1'b0 && gain_o === 2'h0, "reset pins");
        power_on = 1'b1;
        conv_en = 1'b1;
        repeat (200) tick();
        check(asleep === 1'b1 && valid === 1'b0, "woke without start");
        send(TARGET_ADDR_MAIN, 8'h00, ok);
        check(ok === 1'b1, "own address refused");
        // Four wait steps then two integration steps
        k0 = (512 - int'(wait_time_setting) - int'(integ)) * STEP_P;
        check(valid_cyc - wake_cyc >= k0 && valid_cyc - wake_cyc <= k0 + 4, "cycle length");
        // Table rows: settings change mid-cycle, so wait for the settled set
        wait_time_setting = 8'hff;
        foreach (rows[i]) begin
            integ = rows[i].integ;
            gain = rows[i].gain;
            steps = rows[i].cnt;
            e = expect_set(rows[i].integ, rows[i].cnt);
            for (int k = 0; k < 12000 && res !== e; k++) tick();
            check(res === e, "channel results");
            check(gain_o === rows[i].gain, "gain in use");
            check(int_oe === 1'b0, "interrupt while disabled");
        end
        read_check(e);
        send(TARGET_ADDR_ALT, 8'h00, ok);
        check(ok === 1'b0, "foreign address acknowledged");
        // Reset in mid-run clears the count kept while disabled
        rst_n = 1'b0;
        tick();
        tick();
        check(res === '0 && valid === 1'b0 && asleep === 1'b1, "second reset");
        rst_n = 1'b1;
        integ = 8'hfe;
        int_en = 1'b1;
        persist = 4'h2;
        window = '{16'hffff, 16'h0100};
        steps.clear = 11'h001;
        send(TARGET_ADDR_MAIN, 8'h00, ok);
        // Period of one wait step plus two integration steps
        check(int_cyc - valid_cyc >= 60 && int_cyc - valid_cyc <= 68, "persistence");
        window.low = 16'h0000;
        repeat (200) tick();
        check(int_oe === 1'b1, "interrupt dropped");
        send(TARGET_ADDR_ALT, CLEAR_INT_CMD, ok);
        check(int_oe === 1'b1, "cleared by foreign transfer");
        send(TARGET_ADDR_MAIN, CLEAR_INT_CMD, ok);
        check(int_oe === 1'b0, "clear ignored");
        repeat (200) tick();
        check(int_oe === 1'b0, "set while in window");
        // Upper threshold, with a persistence of zero meaning one result
        window.high = 16'h0001;
        persist = 4'h0;
        repeat (200) tick();
        check(int_oe === 1'b1, "upper threshold");
        // Power off drops back to sleep; a start only wakes it briefly
        power_on = 1'b0;
        repeat (200) tick();
        check(asleep === 1'b1, "awake with power off");
        k0 = wake_cyc;
        send(TARGET_ADDR_MAIN, 8'h00, ok);
        check(wake_cyc != k0 && asleep === 1'b1, "start handling in sleep");
        conclude();
    end
endmodule
